// ---- verilog/tdja_top.sv ----
// transmit line driver control with receive and transmit jitter attenuators, APB slave
// How it works
// - global enable pin low puts the line driver in high impedance
// - channel enable bit 6 at zero holds the line driver in high impedance
// - forced high impedance acts at once and leaves other logic running
// - over-current limits drive current, or tri-states when bit 4 set
// - over-current status; interrupt set on rising or any edge per select
// - set unmasked over-current flag drives the interrupt output
// - bit 3 picks single-ended tip-only drive or differential drive
// - software sets termination code bits 2 to 0 by cable and transformer
// - power-down bit tri-states line, ignores and tri-states system side
// - after power-down clears the transmitter settles within 1 ms
// - no master clock edge for over 1 ms tri-states the line
// - line tri-stated during any reset, including global software reset
// - NRZ modes outside remote loop and internal pattern: no transmit clock rising edge for over 64 reference ticks tri-states
// - reference tick rate 1.544 MHz for T1/J1, 2.048 MHz for E1
// - channel soft reset bit 1 or power-down tri-states the line
// - separate receive and transmit attenuators, each enabled by bit 3
// - attenuator FIFO depth 32, 64 or 128 by bits 2 to 1
// - bit 0 selects wide or narrow de-jitter loop bandwidth
// - FIFO overflow or underflow sets receive bit 5 or transmit bit 6
// - attenuator flags reach the interrupt only when unmasked
// - limit bit 4 forces rate change within 2 bits of full or empty
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module tdja_top #(
	parameter int MCLK_LOSS_CYCLES = tdja_pkg::MCLK_LOSS_CYC,
	parameter int TX_SETTLE_CYCLES = tdja_pkg::TX_SETTLE_CYC,
	parameter int JA_MAX_DEPTH = 128
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic OE_PIN_I,
	input wire logic MCLK_I,
	input wire logic TX_SYSTEM_CLK_I,
	input wire logic TX_POS_I,
	input wire logic TX_NEG_I,
	input wire logic TX_OVERCURRENT_I,
	input wire logic TX_NRZ_MODE_I,
	input wire logic REMOTE_LOOP_I,
	input wire logic INT_PATTERN_I,
	input wire logic RX_POS_I,
	input wire logic RX_NEG_I,
	input wire logic RX_STB_I,
	output logic RX_POS_O,
	output logic RX_NEG_O,
	output logic RX_STB_O,
	output logic LINE_TIP_OUT_O,
	output logic LINE_RING_OUT_O,
	output logic LINE_TIP_OE_O,
	output logic LINE_RING_OE_O,
	output logic CURRENT_LIMIT_O,
	output logic [2:0] TERM_SEL_O,
	output logic TX_POWER_DOWN_O,
	output logic TX_SYS_OE_O,
	output logic IRQ_O
);
	import tdja_pkg::*;

	localparam int MCW = $clog2(MCLK_LOSS_CYCLES + 1);
	localparam int SCW = $clog2(TX_SETTLE_CYCLES + 1);
	localparam int PW = $clog2(JA_MAX_DEPTH);

	// pin synchronisers: oe, mclk, tclk, over-current, tx pos, tx neg
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [1:0] edge_q;

	logic [7:0] gcfg, txcfg, chcfg, ies, ist, imsk;
	logic [7:0] next_gcfg, next_txcfg, next_chcfg, next_ies, next_ist, next_imsk;
	tdja_ja_cfg_s ja_cfg [2];
	tdja_ja_cfg_s next_ja_cfg [2];
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [4:0] srst_cnt, next_srst_cnt;
	logic oc_q, next_oc_q;

	tdja_txpwr_e pwr, next_pwr;
	logic [SCW-1:0] settle_cnt, next_settle_cnt;
	logic [MCW-1:0] mclk_cnt, next_mclk_cnt;
	logic [16:0] ref_acc, next_ref_acc;
	logic ref_tick, next_ref_tick;
	logic [6:0] tclk_cnt, next_tclk_cnt;

	logic ja_in_v [2];
	logic [1:0] ja_in_d [2];
	logic ja_out_v [2];
	logic [1:0] ja_out_d [2];
	logic ja_err [2];

	logic e1, oc_s, mclk_edge, tclk_rise, mclk_loss, tclk_loss, pd_bit, line_hiz;
	logic apb_wr, apb_setup, grst_wr;
	logic [7:0] irq_ev;

	assign e1 = gcfg[GCF_E1];
	assign oc_s = sync2[3];
	assign mclk_edge = sync2[1] ^ edge_q[0];
	assign tclk_rise = sync2[2] & ~edge_q[1];
	assign mclk_loss = (mclk_cnt >= MCW'(MCLK_LOSS_CYCLES));
	assign tclk_loss = TX_NRZ_MODE_I & ~REMOTE_LOOP_I & ~INT_PATTERN_I
		& (tclk_cnt > 7'(TCLK_LOSS_REF));
	assign pd_bit = txcfg[TXC_PD];
	assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign apb_setup = PSEL_I & ~PENABLE_I;
	assign grst_wr = apb_wr & (PADDR_I == ADDR_GRST);
	assign PREADY_O = 1'b1;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			edge_q <= 2'h0;
		end else begin
			sync1 <= {TX_NEG_I, TX_POS_I, TX_OVERCURRENT_I, TX_SYSTEM_CLK_I, MCLK_I, OE_PIN_I};
			sync2 <= sync1;
			edge_q <= sync2[2:1];
		end
	end

	// high impedance sources; only the driver enables react, nothing else stops
	assign line_hiz = ~sync2[0]
		| ~txcfg[TXC_OE]
		| (oc_s & txcfg[TXC_OCZ])
		| pd_bit | (pwr != TX_ON)
		| mclk_loss
		| (srst_cnt != 5'h00)
		| chcfg[CHC_RST]
		| tclk_loss;

	// register file and interrupt flags
	always_comb begin
		next_gcfg = gcfg;
		next_txcfg = txcfg;
		next_chcfg = chcfg;
		next_ies = ies;
		next_imsk = imsk;
		next_ja_cfg = ja_cfg;
		next_prdata = PRDATA_O;
		next_pslverr = PSLVERR_O;
		next_oc_q = oc_s;
		next_srst_cnt = (srst_cnt != 5'h00) ? srst_cnt - 5'h01 : 5'h00;
		irq_ev = 8'h00;
		irq_ev[IRQ_OC] = ies[IRQ_OC] ? (oc_s ^ oc_q) : (oc_s & ~oc_q);
		irq_ev[IRQ_RJA] = ja_err[0];
		irq_ev[IRQ_TJA] = ja_err[1];
		next_ist = ist;
		if (apb_wr && PADDR_I == ADDR_IST) begin
			next_ist = ist & ~PWDATA_I[7:0];
		end
		next_ist = next_ist | irq_ev;
		if (apb_setup) begin
			next_pslverr = 1'b0;
			next_prdata = 32'h0000_0000;
			if (PADDR_I == ADDR_GRST) begin
				next_prdata = 32'h0000_0000;
			end else if (PADDR_I == ADDR_GCFG) begin
				next_prdata = {24'h00_0000, gcfg};
			end else if (PADDR_I == ADDR_TXCFG) begin
				next_prdata = {24'h00_0000, txcfg};
			end else if (PADDR_I == ADDR_CHCFG) begin
				next_prdata = {24'h00_0000, chcfg};
			end else if (PADDR_I == ADDR_RJA) begin
				next_prdata = {27'h000_0000, ja_cfg[0]};
			end else if (PADDR_I == ADDR_TJA) begin
				next_prdata = {27'h000_0000, ja_cfg[1]};
			end else if (PADDR_I == ADDR_IES) begin
				next_prdata = {24'h00_0000, ies};
			end else if (PADDR_I == ADDR_IST) begin
				next_prdata = {24'h00_0000, ist};
			end else if (PADDR_I == ADDR_IMSK) begin
				next_prdata = {24'h00_0000, imsk};
			end else if (PADDR_I == ADDR_STAT) begin
				next_prdata = {27'h000_0000, oc_s, (pwr == TX_SETTLE), line_hiz,
					mclk_loss, tclk_loss};
			end else begin
				next_pslverr = 1'b1;
			end
		end
		if (apb_wr) begin
			if (PADDR_I == ADDR_GCFG) begin
				next_gcfg = {7'h00, PWDATA_I[GCF_E1]};
			end else if (PADDR_I == ADDR_TXCFG) begin
				next_txcfg = {1'b0, PWDATA_I[6:0]};
			end else if (PADDR_I == ADDR_CHCFG) begin
				next_chcfg = {6'h00, PWDATA_I[CHC_RST], 1'b0};
			end else if (PADDR_I == ADDR_RJA) begin
				next_ja_cfg[0] = PWDATA_I[4:0];
			end else if (PADDR_I == ADDR_TJA) begin
				next_ja_cfg[1] = PWDATA_I[4:0];
			end else if (PADDR_I == ADDR_IES) begin
				next_ies = PWDATA_I[7:0] & IRQ_USED;
			end else if (PADDR_I == ADDR_IMSK) begin
				next_imsk = PWDATA_I[7:0] | ~IRQ_USED;
			end
		end
		// global software reset returns every register to its reset value
		if (grst_wr) begin
			next_gcfg = GCFG_RST;
			next_txcfg = TXCFG_RST;
			next_chcfg = CHCFG_RST;
			next_ies = IES_RST;
			next_ist = IST_RST;
			next_imsk = IMSK_RST;
			next_ja_cfg[0] = JA_CFG_RST;
			next_ja_cfg[1] = JA_CFG_RST;
			next_srst_cnt = 5'(SRST_HOLD_CYC);
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			gcfg <= GCFG_RST;
			txcfg <= TXCFG_RST;
			chcfg <= CHCFG_RST;
			ies <= IES_RST;
			ist <= IST_RST;
			imsk <= IMSK_RST;
			ja_cfg[0] <= JA_CFG_RST;
			ja_cfg[1] <= JA_CFG_RST;
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
			srst_cnt <= 5'h00;
			oc_q <= 1'b0;
		end else begin
			gcfg <= next_gcfg;
			txcfg <= next_txcfg;
			chcfg <= next_chcfg;
			ies <= next_ies;
			ist <= next_ist;
			imsk <= next_imsk;
			ja_cfg <= next_ja_cfg;
			PRDATA_O <= next_prdata;
			PSLVERR_O <= next_pslverr;
			srst_cnt <= next_srst_cnt;
			oc_q <= next_oc_q;
		end
	end

	// power state, clock watchdogs and reference tick
	always_comb begin
		next_pwr = pwr;
		next_settle_cnt = settle_cnt;
		case (pwr)
			TX_ON: begin
				if (pd_bit) begin
					next_pwr = TX_OFF;
				end
			end
			TX_OFF: begin
				next_settle_cnt = '0;
				if (!pd_bit) begin
					next_pwr = TX_SETTLE;
				end
			end
			TX_SETTLE: begin
				next_settle_cnt = settle_cnt + SCW'(1);
				if (pd_bit) begin
					next_pwr = TX_OFF;
				end else if (settle_cnt >= SCW'(TX_SETTLE_CYCLES - 1)) begin
					next_pwr = TX_ON;
				end
			end
			default: begin
				next_pwr = TX_OFF;
			end
		endcase
		if (mclk_edge) begin
			next_mclk_cnt = '0;
		end else if (!mclk_loss) begin
			next_mclk_cnt = mclk_cnt + MCW'(1);
		end else begin
			next_mclk_cnt = mclk_cnt;
		end
		// fractional divider keeps the average tick rate exact
		next_ref_acc = ref_acc + (e1 ? 17'(E1_REF_KHZ) : 17'(T1_REF_KHZ));
		next_ref_tick = 1'b0;
		if (next_ref_acc >= 17'(CLK_KHZ)) begin
			next_ref_acc = next_ref_acc - 17'(CLK_KHZ);
			next_ref_tick = 1'b1;
		end
		if (tclk_rise) begin
			next_tclk_cnt = 7'h00;
		end else if (ref_tick && tclk_cnt <= 7'(TCLK_LOSS_REF)) begin
			next_tclk_cnt = tclk_cnt + 7'h01;
		end else begin
			next_tclk_cnt = tclk_cnt;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pwr <= TX_ON;
			settle_cnt <= '0;
			mclk_cnt <= '0;
			ref_acc <= 17'h0_0000;
			ref_tick <= 1'b0;
			tclk_cnt <= 7'h00;
		end else begin
			pwr <= next_pwr;
			settle_cnt <= next_settle_cnt;
			mclk_cnt <= next_mclk_cnt;
			ref_acc <= next_ref_acc;
			ref_tick <= next_ref_tick;
			tclk_cnt <= next_tclk_cnt;
		end
	end

	// attenuator inputs; transmit side input ignored while powered down
	assign ja_in_v[0] = RX_STB_I;
	assign ja_in_d[0] = {RX_NEG_I, RX_POS_I};
	assign ja_in_v[1] = tclk_rise & ~pd_bit;
	assign ja_in_d[1] = sync2[5:4];

	genvar j;
	generate
		for (j = 0; j < 2; j++) begin : g_ja
			logic [1:0] mem [JA_MAX_DEPTH];
			logic [PW-1:0] wptr, rptr, next_wptr, next_rptr;
			logic [7:0] fill, next_fill, depth;
			logic [15:0] acc, next_acc;
			logic primed, next_primed, next_out_v, next_err, rd_tick, wr_ok, rd_ok;
			logic [1:0] next_out_d;
			int err, inc;

			always_comb begin
				err = 0;
				inc = 0;
				case (ja_cfg[j].depth)
					2'b00: depth = JA_DEPTH_32;
					2'b01: depth = JA_DEPTH_64;
					default: depth = JA_DEPTH_128;
				endcase
				// read-rate loop: fill error pulls the rate, bandwidth sets the gain
				err = int'(fill) - int'(depth >> 1);
				inc = (e1 ? NCO_NOM_E1 : NCO_NOM_T1)
					+ (ja_cfg[j].bw ? (err >>> JA_NARROW_SHIFT) : (err >>> JA_WIDE_SHIFT));
				if (ja_cfg[j].limit) begin
					if (int'(fill) >= int'(depth) - JA_MARGIN) begin
						inc = inc + (NCO_NOM_T1 >> 3);
					end else if (int'(fill) <= JA_MARGIN) begin
						inc = inc - (NCO_NOM_T1 >> 3);
					end
				end
				{rd_tick, next_acc} = {1'b0, acc} + 17'(inc);
				wr_ok = ja_in_v[j] & (fill < depth);
				rd_ok = rd_tick & primed & (fill != 8'h00);
				next_wptr = wr_ok ? PW'((wptr + PW'(1)) & PW'(depth - 8'h01)) : wptr;
				next_rptr = rd_ok ? PW'((rptr + PW'(1)) & PW'(depth - 8'h01)) : rptr;
				next_fill = fill + {7'h00, wr_ok} - {7'h00, rd_ok};
				next_primed = primed | (fill >= (depth >> 1));
				// overflow drops the bit; underflow waits for half fill again
				next_err = (ja_in_v[j] & (fill >= depth))
					| (rd_tick & primed & (fill == 8'h00));
				if (rd_tick && primed && fill == 8'h00) begin
					next_primed = 1'b0;
				end
				next_out_v = rd_ok;
				next_out_d = mem[rptr];
				if (!ja_cfg[j].en) begin
					next_wptr = '0;
					next_rptr = '0;
					next_fill = 8'h00;
					next_primed = 1'b0;
					next_acc = 16'h0000;
					next_err = 1'b0;
					next_out_v = ja_in_v[j];
					next_out_d = ja_in_d[j];
				end
			end

			always_ff @(posedge CLK_I) begin
				if (wr_ok && ja_cfg[j].en) begin
					mem[wptr] <= ja_in_d[j];
				end
			end

			always_ff @(posedge CLK_I or posedge RST_I) begin
				if (RST_I) begin
					wptr <= '0;
					rptr <= '0;
					fill <= 8'h00;
					acc <= 16'h0000;
					primed <= 1'b0;
					ja_out_v[j] <= 1'b0;
					ja_out_d[j] <= 2'h0;
					ja_err[j] <= 1'b0;
				end else begin
					wptr <= next_wptr;
					rptr <= next_rptr;
					fill <= next_fill;
					acc <= next_acc;
					primed <= next_primed;
					ja_out_v[j] <= next_out_v;
					ja_out_d[j] <= next_out_d;
					ja_err[j] <= next_err;
				end
			end
		end
	endgenerate

	// registered outputs
	logic next_tip, next_ring, next_tip_oe, next_ring_oe, next_irq;
	logic next_tip_d, next_ring_d, next_climit;
	always_comb begin
		next_tip_oe = ~line_hiz & ~RST_I;
		next_ring_oe = ~line_hiz & ~txcfg[TXC_SE];
		next_tip_d = LINE_TIP_OUT_O;
		next_ring_d = LINE_RING_OUT_O;
		if (ja_out_v[1]) begin
			next_tip_d = txcfg[TXC_SE] ? (ja_out_d[1][0] | ja_out_d[1][1]) : ja_out_d[1][0];
			next_ring_d = txcfg[TXC_SE] ? 1'b0 : ja_out_d[1][1];
		end
		next_tip = next_tip_d;
		next_ring = next_ring_d;
		next_climit = oc_s & ~txcfg[TXC_OCZ];
		next_irq = |(ist & ~imsk & IRQ_USED);
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			LINE_TIP_OUT_O <= 1'b0;
			LINE_RING_OUT_O <= 1'b0;
			LINE_TIP_OE_O <= 1'b0;
			LINE_RING_OE_O <= 1'b0;
			CURRENT_LIMIT_O <= 1'b0;
			TERM_SEL_O <= 3'h0;
			TX_POWER_DOWN_O <= 1'b0;
			TX_SYS_OE_O <= 1'b0;
			IRQ_O <= 1'b0;
			RX_POS_O <= 1'b0;
			RX_NEG_O <= 1'b0;
			RX_STB_O <= 1'b0;
		end else begin
			LINE_TIP_OUT_O <= next_tip;
			LINE_RING_OUT_O <= next_ring;
			LINE_TIP_OE_O <= next_tip_oe;
			LINE_RING_OE_O <= next_ring_oe;
			CURRENT_LIMIT_O <= next_climit;
			TERM_SEL_O <= txcfg[TXC_TERM_LSB +: 3];
			TX_POWER_DOWN_O <= pd_bit;
			TX_SYS_OE_O <= ~pd_bit;
			IRQ_O <= next_irq;
			RX_POS_O <= ja_out_d[0][0];
			RX_NEG_O <= ja_out_d[0][1];
			RX_STB_O <= ja_out_v[0];
		end
	end
endmodule

// ---- verilog/tdja_pkg.sv ----
// shared constants and types for the transmit driver control and jitter attenuator block
package tdja_pkg;
	// clock rate and reference rates
	localparam int CLK_KHZ = 100000;
	localparam int T1_REF_KHZ = 1544;
	localparam int E1_REF_KHZ = 2048;
	// times in their own unit and derived cycle counts
	localparam int MCLK_LOSS_US = 1000;
	localparam int MCLK_LOSS_CYC = (MCLK_LOSS_US * CLK_KHZ) / 1000;
	localparam int TX_SETTLE_US = 1000;
	localparam int TX_SETTLE_CYC = (TX_SETTLE_US * CLK_KHZ) / 1000;
	localparam int TCLK_LOSS_REF = 64;
	localparam int SRST_HOLD_CYC = 16;
	localparam int OC_LIMIT_MA = 100;
	// register byte offsets
	localparam logic [7:0] ADDR_GRST = 8'h00;
	localparam logic [7:0] ADDR_GCFG = 8'h04;
	localparam logic [7:0] ADDR_TXCFG = 8'h08;
	localparam logic [7:0] ADDR_CHCFG = 8'h0C;
	localparam logic [7:0] ADDR_RJA = 8'h10;
	localparam logic [7:0] ADDR_TJA = 8'h14;
	localparam logic [7:0] ADDR_IES = 8'h18;
	localparam logic [7:0] ADDR_IST = 8'h1C;
	localparam logic [7:0] ADDR_IMSK = 8'h20;
	localparam logic [7:0] ADDR_STAT = 8'h24;
	// field positions
	localparam int GCF_E1 = 0;
	localparam int TXC_OE = 6;
	localparam int TXC_PD = 5;
	localparam int TXC_OCZ = 4;
	localparam int TXC_SE = 3;
	localparam int TXC_TERM_LSB = 0;
	localparam int CHC_RST = 1;
	localparam int IRQ_OC = 4;
	localparam int IRQ_RJA = 5;
	localparam int IRQ_TJA = 6;
	localparam int ST_TCLK_LOSS = 0;
	localparam int ST_MCLK_LOSS = 1;
	localparam int ST_LINE_HIZ = 2;
	localparam int ST_SETTLING = 3;
	localparam int ST_OC = 4;
	// values after reset and the used interrupt bits
	localparam logic [7:0] GCFG_RST = 8'h00;
	localparam logic [7:0] TXCFG_RST = 8'h40;
	localparam logic [7:0] CHCFG_RST = 8'h00;
	localparam logic [7:0] IES_RST = 8'h00;
	localparam logic [7:0] IST_RST = 8'h00;
	localparam logic [7:0] IMSK_RST = 8'hFF;
	localparam logic [7:0] IRQ_USED = 8'h70;
	// jitter attenuator depths and rate loop
	localparam logic [7:0] JA_DEPTH_32 = 8'h20;
	localparam logic [7:0] JA_DEPTH_64 = 8'h40;
	localparam logic [7:0] JA_DEPTH_128 = 8'h80;
	localparam int JA_MARGIN = 2;
	localparam int NCO_NOM_T1 = (T1_REF_KHZ * 65536) / CLK_KHZ;
	localparam int NCO_NOM_E1 = (E1_REF_KHZ * 65536) / CLK_KHZ;
	localparam int JA_WIDE_SHIFT = 2;
	localparam int JA_NARROW_SHIFT = 5;

	typedef struct packed {
		logic limit;
		logic en;
		logic [1:0] depth;
		logic bw;
	} tdja_ja_cfg_s;
	localparam tdja_ja_cfg_s JA_CFG_RST = 5'h00;

	typedef enum logic [1:0] {
		TX_ON = 2'b00,
		TX_OFF = 2'b01,
		TX_SETTLE = 2'b10
	} tdja_txpwr_e;
endpackage

// ---- testbench/tdja_top_asserts.sv ----
// concurrent checks on the line driver control block ports
`timescale 1ns/1ps
module tdja_top_chk
	import tdja_pkg::*;
#(
	parameter int MCLK_LOSS_CYCLES = 200
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic OE_PIN_I,
	input wire logic MCLK_I,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic LINE_TIP_OE_O,
	input wire logic LINE_RING_OE_O,
	input wire logic [2:0] TERM_SEL_O,
	input wire logic TX_POWER_DOWN_O,
	input wire logic TX_SYS_OE_O,
	input wire logic IRQ_O
);
	logic [1:0] wr_q, next_wr_q;
	logic mclk_q, next_mclk_q;
	logic [31:0] idle, next_idle;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	always_comb begin
		next_wr_q = {wr_q[0], PSEL_I && PENABLE_I && PWRITE_I &&
			(PADDR_I == ADDR_TXCFG || PADDR_I == ADDR_GRST)};
		next_mclk_q = MCLK_I;
		// raw pin: runs ahead of the synced copy, hence the slack below
		next_idle = (MCLK_I != mclk_q) ? 32'h0000_0000 : idle + 32'h0000_0001;
	end
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_q <= 2'h0;
			mclk_q <= 1'b0;
			idle <= 32'h0000_0000;
		end else begin
			wr_q <= next_wr_q;
			mclk_q <= next_mclk_q;
			idle <= next_idle;
		end
	end
	rst_hiz_a:
	assert property (disable iff (1'b0) RST_I |-> !LINE_TIP_OE_O && !LINE_RING_OE_O)
		else $error("line driven during reset");
	oe_pin_a:
	assert property (!OE_PIN_I [*4] |-> !LINE_TIP_OE_O && !LINE_RING_OE_O)
		else $error("line driven with enable pin low");
	pd_hiz_a:
	assert property (TX_POWER_DOWN_O [*3] |-> !LINE_TIP_OE_O && !LINE_RING_OE_O)
		else $error("line driven in power down");
	sys_oe_a:
	assert property (!$past(RST_I) |-> TX_SYS_OE_O == !TX_POWER_DOWN_O)
		else $error("system enable disagrees with power down");
	ring_tip_a:
	assert property (LINE_RING_OE_O |-> LINE_TIP_OE_O)
		else $error("ring driven without tip");
	apb_err_a:
	assert property (PSEL_I && !PENABLE_I && PADDR_I > ADDR_STAT |=> PSLVERR_O && PREADY_O)
		else $error("unmapped access not flagged");
	term_wr_a:
	assert property ($changed(TERM_SEL_O) |-> wr_q != 2'h0)
		else $error("termination changed without a write");
	mclk_loss_a:
	assert property (idle > 32'(MCLK_LOSS_CYCLES + 6) |-> !LINE_TIP_OE_O)
		else $error("line driven after master clock loss");
	irq_rst_a:
	assert property ($fell(RST_I) |-> !IRQ_O [*2])
		else $error("interrupt raised out of reset");
endmodule

bind tdja_top tdja_top_chk #(
	.MCLK_LOSS_CYCLES(MCLK_LOSS_CYCLES)
) chk_u (
	.CLK_I(CLK_I),
	.RST_I(RST_I),
	.PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I),
	.OE_PIN_I(OE_PIN_I),
	.MCLK_I(MCLK_I),
	.PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O),
	.LINE_TIP_OE_O(LINE_TIP_OE_O),
	.LINE_RING_OE_O(LINE_RING_OE_O),
	.TERM_SEL_O(TERM_SEL_O),
	.TX_POWER_DOWN_O(TX_POWER_DOWN_O),
	.TX_SYS_OE_O(TX_SYS_OE_O),
	.IRQ_O(IRQ_O)
);

// ---- testbench/tdja_line_model.sv ----
// line load that can present a short to the driver
`timescale 1ns/1ps
module tdja_line_model (
	input wire logic clk_i,
	input wire logic short_i,
	output logic oc_o
);
	// sensed at the transformer, so a short persists while the driver is released
	always_ff @(posedge clk_i) begin
		oc_o <= short_i;
	end
endmodule

// ---- testbench/tdja_top_tb.sv ----
// self-checking bench for the line driver control block
`timescale 1ns/1ps
module tdja_top_tb;
	import tdja_pkg::*;
	localparam int MLOSS = 200;
	localparam int SETTLE = 50;
	logic CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, OE_PIN_I, MCLK_I, TX_SYSTEM_CLK_I;
	logic TX_NRZ_MODE_I, REMOTE_LOOP_I, INT_PATTERN_I, short, mclk_run, tclk_run, er;
	logic PREADY_O, PSLVERR_O, LINE_TIP_OE_O, LINE_RING_OE_O, CURRENT_LIMIT_O;
	logic TX_POWER_DOWN_O, TX_SYS_OE_O, IRQ_O, TX_OVERCURRENT_I, rx_stb, rx_stb_o;
	logic [7:0] PADDR_I;
	logic [31:0] PWDATA_I, PRDATA_O, rd;
	logic [2:0] TERM_SEL_O;
	logic [4:0] cnt;
	int miscompares, total_checks, cyc;

	tdja_top #(
		.MCLK_LOSS_CYCLES(MLOSS),
		.TX_SETTLE_CYCLES(SETTLE),
		.JA_MAX_DEPTH(128)
	) dut_u (
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I),
		.PWRITE_I(PWRITE_I),
		.PADDR_I(PADDR_I),
		.PWDATA_I(PWDATA_I),
		.PRDATA_O(PRDATA_O),
		.PREADY_O(PREADY_O),
		.PSLVERR_O(PSLVERR_O),
		.OE_PIN_I(OE_PIN_I),
		.MCLK_I(MCLK_I),
		.TX_SYSTEM_CLK_I(TX_SYSTEM_CLK_I),
		.TX_POS_I(1'b1),
		.TX_NEG_I(1'b0),
		.TX_OVERCURRENT_I(TX_OVERCURRENT_I),
		.TX_NRZ_MODE_I(TX_NRZ_MODE_I),
		.REMOTE_LOOP_I(REMOTE_LOOP_I),
		.INT_PATTERN_I(INT_PATTERN_I),
		.RX_POS_I(1'b0),
		.RX_NEG_I(1'b0),
		.RX_STB_I(rx_stb),
		.RX_POS_O(),
		.RX_NEG_O(),
		.RX_STB_O(rx_stb_o),
		.LINE_TIP_OUT_O(),
		.LINE_RING_OUT_O(),
		.LINE_TIP_OE_O(LINE_TIP_OE_O),
		.LINE_RING_OE_O(LINE_RING_OE_O),
		.CURRENT_LIMIT_O(CURRENT_LIMIT_O),
		.TERM_SEL_O(TERM_SEL_O),
		.TX_POWER_DOWN_O(TX_POWER_DOWN_O),
		.TX_SYS_OE_O(TX_SYS_OE_O),
		.IRQ_O(IRQ_O)
	);
	tdja_line_model line_u (
		.clk_i(CLK_I),
		.short_i(short),
		.oc_o(TX_OVERCURRENT_I)
	);

	initial begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end
	// master clock at an eighth of the clock rate, transmit clock rising every 64 cycles
	always @(posedge CLK_I) begin
		cnt <= cnt + 5'h01;
		if (mclk_run && cnt[1:0] == 2'h3)
			MCLK_I <= ~MCLK_I;
		if (tclk_run && cnt == 5'h1F)
			TX_SYSTEM_CLK_I <= ~TX_SYSTEM_CLK_I;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge CLK_I);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK_I);
		PSEL_I <= 1'b1;
		PENABLE_I <= 1'b0;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_I);
			n++;
		end while (PREADY_O !== 1'b1 && n < 16);
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		chk("pready", 32'h1, PREADY_O);
		if (PREADY_O !== 1'b1)
			end_sim;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	// waits for the tip enable to reach e; cyc holds the wait
	task automatic wt(input logic e, input int lim);
		cyc = 0;
		@(negedge CLK_I);
		while (LINE_TIP_OE_O !== e && cyc < lim) begin
			@(negedge CLK_I);
			cyc++;
		end
		chk("line_oe", e, LINE_TIP_OE_O);
		if (LINE_TIP_OE_O !== e)
			end_sim;
	endtask

	task automatic t_regs;
		int i;
		rdc("txcfg", ADDR_TXCFG, {24'h00_0000, TXCFG_RST});
		rdc("mask", ADDR_IMSK, {24'h00_0000, IMSK_RST});
		apb(1'b0, 8'h30, 32'h0000_0000);
		chk("slverr", 32'h1, er);
		// attenuators are off after reset, so the receive strobe passes straight through
		@(posedge CLK_I);
		rx_stb <= 1'b1;
		@(posedge CLK_I);
		rx_stb <= 1'b0;
		nc(2);
		chk("rx_pass", 32'h1, rx_stb_o);
		// external matching code 111 is only legal in E1 differential use
		wr(ADDR_GCFG, 32'h0000_0001);
		for (i = 0; i < 8; i++) begin
			wr(ADDR_TXCFG, 32'h0000_0040 | i);
			nc(3);
			chk("term", i, TERM_SEL_O);
		end
		wr(ADDR_TXCFG, 32'h0000_0040);
		wr(ADDR_GCFG, 32'h0000_0000);
		$display("regs done");
	endtask
	task automatic t_oe;
		@(posedge CLK_I);
		OE_PIN_I <= 1'b0;
		wt(1'b0, 6);
		chk("ring_oe", 32'h0, LINE_RING_OE_O);
		chk("sys_oe", 32'h1, TX_SYS_OE_O);
		@(posedge CLK_I);
		OE_PIN_I <= 1'b1;
		wt(1'b1, 8);
		wr(ADDR_TXCFG, 32'h0000_0000);
		wt(1'b0, 4);
		wr(ADDR_TXCFG, 32'h0000_0048);
		wt(1'b1, 6);
		chk("ring_se", 32'h0, LINE_RING_OE_O);
		wr(ADDR_TXCFG, 32'h0000_0040);
		nc(4);
		chk("ring_diff", 32'h1, LINE_RING_OE_O);
		$display("enable done");
	endtask
	task automatic t_oc;
		@(posedge CLK_I);
		short <= 1'b1;
		nc(6);
		chk("limit", 32'h1, CURRENT_LIMIT_O);
		chk("oe_limit", 32'h1, LINE_TIP_OE_O);
		rdc("oc_stat", ADDR_STAT, 32'h0000_0010);
		rdc("oc_flag", ADDR_IST, 32'h0000_0010);
		nc(1);
		chk("irq_masked", 32'h0, IRQ_O);
		wr(ADDR_IMSK, 32'h0000_00EF);
		nc(3);
		chk("irq", 32'h1, IRQ_O);
		wr(ADDR_IST, 32'h0000_0010);
		nc(3);
		chk("irq_clr", 32'h0, IRQ_O);
		@(posedge CLK_I);
		short <= 1'b0;
		nc(6);
		chk("fall_ignored", 32'h0, IRQ_O);
		wr(ADDR_IES, 32'h0000_0010);
		@(posedge CLK_I);
		short <= 1'b1;
		nc(6);
		wr(ADDR_IST, 32'h0000_0010);
		@(posedge CLK_I);
		short <= 1'b0;
		nc(6);
		chk("fall_any", 32'h1, IRQ_O);
		wr(ADDR_TXCFG, 32'h0000_0050);
		@(posedge CLK_I);
		short <= 1'b1;
		wt(1'b0, 10);
		chk("limit_hiz", 32'h0, CURRENT_LIMIT_O);
		@(posedge CLK_I);
		short <= 1'b0;
		wt(1'b1, 10);
		wr(ADDR_IMSK, 32'h0000_00FF);
		wr(ADDR_IST, 32'h0000_0070);
		wr(ADDR_TXCFG, 32'h0000_0040);
		$display("overcurrent done");
	endtask
	task automatic t_pd;
		wr(ADDR_TXCFG, 32'h0000_0060);
		wt(1'b0, 6);
		chk("pd_out", 32'h1, TX_POWER_DOWN_O);
		chk("sys_oe_pd", 32'h0, TX_SYS_OE_O);
		wr(ADDR_TXCFG, 32'h0000_0040);
		wt(1'b1, 200);
		chk("settle", 32'h1, cyc >= SETTLE - 6 && cyc <= SETTLE + 6);
		$display("power down done");
	endtask
	task automatic t_mclk;
		@(posedge CLK_I);
		mclk_run <= 1'b0;
		wt(1'b0, 300);
		chk("mloss_time", 32'h1, cyc >= MLOSS - 8 && cyc <= MLOSS + 8);
		@(posedge CLK_I);
		mclk_run <= 1'b1;
		wt(1'b1, 20);
		$display("master clock done");
	endtask
	task automatic t_tclk;
		int m;
		int e;
		for (m = 0; m < 2; m++) begin
			wr(ADDR_GCFG, m);
			e = 65 * CLK_KHZ / (m == 1 ? E1_REF_KHZ : T1_REF_KHZ);
			@(posedge CLK_I);
			tclk_run <= 1'b0;
			wt(1'b0, 6000);
			chk("tloss_time", 32'h1, cyc >= e - 140 && cyc <= e + 140);
			@(posedge CLK_I);
			{REMOTE_LOOP_I, INT_PATTERN_I} <= 2'(m + 1);
			wt(1'b1, 10);
			@(posedge CLK_I);
			{REMOTE_LOOP_I, INT_PATTERN_I} <= 2'h0;
			tclk_run <= 1'b1;
			nc(80);
			wt(1'b1, 200);
		end
		wr(ADDR_GCFG, 32'h0000_0000);
		// outside the NRZ modes a stopped transmit clock must not release the line
		@(posedge CLK_I);
		TX_NRZ_MODE_I <= 1'b0;
		tclk_run <= 1'b0;
		nc(4400);
		chk("tloss_not_nrz", 32'h1, LINE_TIP_OE_O);
		@(posedge CLK_I);
		TX_NRZ_MODE_I <= 1'b1;
		tclk_run <= 1'b1;
		nc(80);
		wt(1'b1, 200);
		$display("transmit clock done");
	endtask
	task automatic t_rst;
		wr(ADDR_CHCFG, 32'h0000_0002);
		wt(1'b0, 6);
		wr(ADDR_CHCFG, 32'h0000_0000);
		wt(1'b1, 20);
		wr(ADDR_TXCFG, 32'h0000_0048);
		wr(ADDR_GRST, 32'h0000_0000);
		wt(1'b0, 6);
		wt(1'b1, 40);
		rdc("txcfg_grst", ADDR_TXCFG, 32'h0000_0040);
		@(posedge CLK_I);
		RST_I <= 1'b1;
		nc(3);
		chk("oe_hwrst", 32'h0, LINE_TIP_OE_O);
		@(posedge CLK_I);
		RST_I <= 1'b0;
		wt(1'b1, 20);
		$display("reset done");
	endtask

	initial begin
		{RST_I, OE_PIN_I, TX_NRZ_MODE_I, mclk_run, tclk_run} = 5'h1F;
		{PSEL_I, PENABLE_I, PWRITE_I, MCLK_I, TX_SYSTEM_CLK_I} = 5'h00;
		{REMOTE_LOOP_I, INT_PATTERN_I, short, rx_stb} = 4'h0;
		PADDR_I = 8'h00;
		PWDATA_I = 32'h0000_0000;
		cnt = 5'h00;
		miscompares = 0;
		total_checks = 0;
		repeat (12) @(posedge CLK_I);
		RST_I <= 1'b0;
		wt(1'b1, 20);
		t_regs;
		t_oe;
		t_oc;
		t_pd;
		t_mclk;
		t_tclk;
		t_rst;
		end_sim;
	end
endmodule
